// file: verilog/tws_pkg.sv
/*
 Shared constants for the two-wire register slave: register offsets, reset
 values, fixed address bits and the one-hot state and byte-kind codes.
 Assumes every importer works on 8-bit register offsets and data.
*/
`default_nettype none
package tws_pkg;
    // Register offsets
    localparam logic [7:0] OFF_VENDOR_LO = 8'h00;
    localparam logic [7:0] OFF_VENDOR_HI = 8'h01;
    localparam logic [7:0] OFF_PART_LO = 8'h02;
    localparam logic [7:0] OFF_PART_HI = 8'h03;
    localparam logic [7:0] OFF_REVISION = 8'h04;
    localparam logic [7:0] OFF_RSVD_FIXED = 8'h05;
    localparam logic [7:0] OFF_MIN_FREQ = 8'h06;
    localparam logic [7:0] OFF_MAX_FREQ = 8'h07;
    localparam logic [7:0] OFF_CONFIG1 = 8'h08;
    // First offset handed to the scaler register set
    localparam logic [7:0] OFF_SCALER_BASE = 8'h80;
    // Fixed and reset values
    localparam logic [7:0] VAL_RSVD_FIXED = 8'hA5;
    localparam logic [7:0] VAL_MIN_FREQ = 8'h19;
    localparam logic [7:0] VAL_MAX_FREQ_FULL = 8'hA2;
    localparam logic [7:0] VAL_MAX_FREQ_MID = 8'h55;
    localparam logic [7:0] RST_CONFIG1 = 8'h39;
    // Bits 1, 6 and 7 of config_primary are reserved and read zero
    localparam logic [7:0] CONFIG_PRIMARY_WMASK = 8'h3D;
    localparam int CONFIG_PRIMARY_PWR_BIT = 0;
    // Upper four bits of the bus address
    localparam logic [3:0] ADDR_FIXED = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Protocol states
    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b00001,
        ST_RECV = 5'b00010,
        ST_ACK = 5'b00100,
        ST_SEND = 5'b01000,
        ST_MACK = 5'b10000
    } tws_state_e;
    // Which byte of a write sequence is being received
    typedef enum logic [2:0]
    {
        K_ADDR = 3'b001,
        K_REG = 3'b010,
        K_DATA = 3'b100
    } tws_kind_e;
endpackage
`default_nettype wire

// file: verilog/tws_cond_if.sv
/*
 Bus-condition carrier between the line watcher and the protocol engine.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface tws_cond_if;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda_lvl;
    modport det (output start, output stop, output rise, output fall, output sda_lvl);
    modport fsm (input start, input stop, input rise, input fall, input sda_lvl);
endinterface
`default_nettype wire

// file: verilog/tws_bus_cond.sv
/*
 Line watcher: turns sampled clock and data levels into start, stop and
 clock-edge events. Assumes scl and sda are already synchronous to ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module tws_bus_cond
    import tws_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    // Events
    tws_cond_if.det cond
);
    logic scl_q;
    logic sda_q;
    logic next_scl_q;
    logic next_sda_q;

    // Previous levels; idle bus is high on both lines
    always_comb
    begin
        next_scl_q = scl;
        next_sda_q = sda;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= next_scl_q;
            sda_q <= next_sda_q;
        end
    end

    // Data moving while clock stays high marks start or stop
    assign cond.start = scl && scl_q && sda_q && !sda;
    assign cond.stop = scl && scl_q && !sda_q && sda;
    assign cond.rise = scl && !scl_q;
    assign cond.fall = !scl && scl_q;
    assign cond.sda_lvl = sda;
endmodule // tws_bus_cond
`default_nettype wire

// file: verilog/tws_slave.sv
/*
 Two-wire serial slave with the host control registers 00h..08h and a
 pass-through port to the scaler register set.
 Assumes scl/sda arrive synchronous to ref_clk, far slower than it.
*/
`timescale 1ns/1ns
`default_nettype none
module tws_slave
    import tws_pkg::*;
#(
    // Identity bytes; values are arbitrary
    parameter logic [7:0] VENDOR_LO = 8'h3C,
    parameter logic [7:0] VENDOR_HI = 8'h4D,
    parameter logic [7:0] PART_LO = 8'h7E,
    parameter logic [7:0] PART_HI = 8'h2B,
    parameter logic [7:0] REVISION = 8'h0A,
    parameter logic [7:0] SCALER_BASE = OFF_SCALER_BASE
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and sense pins
    input wire logic [2:0] addr_select,
    input wire logic pix_mode_mid,
    input wire logic panel_sense,
    // Device control
    output logic [7:0] config_primary,
    output logic power_normal,
    output logic panel_attached,
    // Scaler register set
    output logic scaler_wr,
    output logic [7:0] scaler_addr,
    output logic [7:0] scaler_wdata,
    input wire logic [7:0] scaler_rdata
);
    // Scaler window must sit above the host registers
    if (SCALER_BASE <= OFF_CONFIG1)
    begin : g_chk
        $error("scaler base overlaps host registers");
    end

    tws_cond_if cond ();

    tws_bus_cond u_cond
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .scl(scl),
        .sda(sda_in),
        .cond(cond)
    );

    tws_state_e state, next_state;
    tws_kind_e kind, next_kind;
    logic [2:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;
    logic done, next_done;
    logic rw, next_rw;
    logic [7:0] ptr, next_ptr;
    logic [2:0] sel, next_sel;
    logic latched, next_latched;
    logic next_sda_oe;
    logic [7:0] part_hi, next_part_hi;
    logic [7:0] rev, next_rev;
    logic [7:0] next_config;
    logic next_scaler_wr;
    logic [7:0] next_scaler_addr, next_scaler_wdata;
    logic [7:0] rd_val;
    logic writable;
    logic addr_match;

    // Read mux; unmapped host offsets read zero
    always_comb
    begin
        rd_val = 8'h00;
        if (ptr >= SCALER_BASE)
            rd_val = scaler_rdata;
        else
        begin
            unique case (ptr)
                OFF_VENDOR_LO: rd_val = VENDOR_LO;
                OFF_VENDOR_HI: rd_val = VENDOR_HI;
                OFF_PART_LO: rd_val = PART_LO;
                OFF_PART_HI: rd_val = part_hi;
                OFF_REVISION: rd_val = rev;
                OFF_RSVD_FIXED: rd_val = VAL_RSVD_FIXED;
                OFF_MIN_FREQ: rd_val = VAL_MIN_FREQ;
                OFF_MAX_FREQ: rd_val = pix_mode_mid ? VAL_MAX_FREQ_MID : VAL_MAX_FREQ_FULL;
                OFF_CONFIG1: rd_val = config_primary;
                default: rd_val = 8'h00;
            endcase
        end
    end

    // Only the writable host registers and the scaler window take data
    assign writable = (ptr == OFF_PART_HI) || (ptr == OFF_REVISION) ||
        (ptr == OFF_CONFIG1) || (ptr >= SCALER_BASE);
    assign addr_match = (sh[7:1] == {ADDR_FIXED, sel});

    // Protocol engine, advanced only by start, stop and clock edges
    always_comb
    begin
        next_state = state;
        next_kind = kind;
        next_cnt = cnt;
        next_sh = sh;
        next_done = done;
        next_rw = rw;
        next_ptr = ptr;
        next_sel = sel;
        next_latched = latched;
        next_sda_oe = sda_oe;
        next_part_hi = part_hi;
        next_rev = rev;
        next_config = config_primary;
        next_scaler_wr = 1'b0;
        next_scaler_addr = scaler_addr;
        next_scaler_wdata = scaler_wdata;
        if (cond.stop)
        begin
            // Stop always frees the line; pointer is kept
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end
        else if (cond.start)
        begin
            // Start and repeated start both open an address byte
            next_state = ST_RECV;
            next_kind = K_ADDR;
            next_cnt = 3'h0;
            next_done = 1'b0;
            next_sda_oe = 1'b0;
            if (!latched)
            begin
                next_latched = 1'b1;
                next_sel = addr_select;
            end
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    next_sda_oe = 1'b0;
                end
                ST_RECV:
                begin
                    if (cond.rise && !done)
                    begin
                        next_sh = {sh[6:0], cond.sda_lvl};
                        next_cnt = cnt + 3'h1;
                        next_done = (cnt == BIT_LAST);
                    end
                    else if (cond.fall && done)
                    begin
                        next_done = 1'b0;
                        next_state = ST_ACK;
                        next_sda_oe = 1'b1;
                        if (kind == K_ADDR)
                        begin
                            next_rw = sh[0];
                            if (!addr_match)
                            begin
                                next_state = ST_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end
                        else if (kind == K_REG)
                            next_ptr = sh;
                        else if (writable)
                        begin
                            // Store, then step to the next register
                            next_ptr = ptr + 8'h01;
                            if (ptr >= SCALER_BASE)
                            begin
                                next_scaler_wr = 1'b1;
                                next_scaler_addr = ptr;
                                next_scaler_wdata = sh;
                            end
                            else if (ptr == OFF_PART_HI)
                                next_part_hi = sh;
                            else if (ptr == OFF_REVISION)
                                next_rev = sh;
                            else
                                next_config = sh & CONFIG_PRIMARY_WMASK;
                        end
                        else
                        begin
                            // Withhold ack and wait for the master's stop
                            next_state = ST_IDLE;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (cond.fall)
                    begin
                        next_cnt = 3'h0;
                        if (kind == K_ADDR && rw)
                        begin
                            // Current-address read starts at the kept pointer
                            next_state = ST_SEND;
                            next_sh = rd_val;
                            next_sda_oe = ~rd_val[7];
                        end
                        else
                        begin
                            next_state = ST_RECV;
                            next_kind = (kind == K_ADDR) ? K_REG : K_DATA;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                ST_SEND:
                begin
                    if (cond.fall)
                    begin
                        if (cnt == BIT_LAST)
                        begin
                            next_state = ST_MACK;
                            next_sda_oe = 1'b0;
                        end
                        else
                        begin
                            next_cnt = cnt + 3'h1;
                            next_sh = {sh[6:0], 1'b0};
                            next_sda_oe = ~sh[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (cond.rise)
                    begin
                        // Either answer is legal after a read byte
                        if (!cond.sda_lvl)
                        begin
                            next_done = 1'b1;
                            next_ptr = ptr + 8'h01;
                        end
                        else
                            next_state = ST_IDLE;
                    end
                    else if (cond.fall && done)
                    begin
                        next_done = 1'b0;
                        next_cnt = 3'h0;
                        next_state = ST_SEND;
                        next_sh = rd_val;
                        next_sda_oe = ~rd_val[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            kind <= K_ADDR;
            cnt <= 3'h0;
            sh <= 8'h00;
            done <= 1'b0;
            rw <= 1'b0;
            ptr <= 8'h00;
            sel <= 3'h0;
            latched <= 1'b0;
            sda_oe <= 1'b0;
            part_hi <= PART_HI;
            rev <= REVISION;
            config_primary <= RST_CONFIG1;
            scaler_wr <= 1'b0;
            scaler_addr <= 8'h00;
            scaler_wdata <= 8'h00;
        end
        else
        begin
            state <= next_state;
            kind <= next_kind;
            cnt <= next_cnt;
            sh <= next_sh;
            done <= next_done;
            rw <= next_rw;
            ptr <= next_ptr;
            sel <= next_sel;
            latched <= next_latched;
            sda_oe <= next_sda_oe;
            part_hi <= next_part_hi;
            rev <= next_rev;
            config_primary <= next_config;
            scaler_wr <= next_scaler_wr;
            scaler_addr <= next_scaler_addr;
            scaler_wdata <= next_scaler_wdata;
        end
    end

    // Pin side: data only ever pulled low, panel sense and power bit registered
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sda_out <= 1'b0;
            power_normal <= 1'b1;
            panel_attached <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
            power_normal <= config_primary[CONFIG_PRIMARY_PWR_BIT];
            panel_attached <= panel_sense;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_addr_done;
        state == ST_RECV && kind == K_ADDR && done && cond.fall;
    endsequence

    sequence s_read_turn;
        state == ST_ACK && kind == K_ADDR && rw && cond.fall && !cond.stop && !cond.start;
    endsequence

    a_addr_match_ack: assert property (s_addr_done and !cond.stop and !cond.start
        |=> (sda_oe == $past(addr_match))) else $error("address ack wrong");
    a_sel_frozen: assert property ($past(latched) |-> $stable(sel))
        else $error("select bits changed after latch");
    a_sda_pull_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_ack_held_low: assert property (state == ST_ACK |-> sda_oe)
        else $error("ack not driven");
    a_msb_first_out: assert property (s_read_turn |=> sda_oe == ~$past(rd_val[7]))
        else $error("first read bit not msb");
    a_ro_nack: assert property (state == ST_RECV && kind == K_DATA && done && cond.fall
        && !cond.stop && !cond.start && !writable |=> state == ST_IDLE && !sda_oe)
        else $error("read-only byte acknowledged");
    a_write_step: assert property (state == ST_RECV && kind == K_DATA && done && cond.fall
        && !cond.stop && !cond.start && writable |=> ptr == $past(ptr) + 8'h01)
        else $error("write pointer not stepped");
    a_nack_release: assert property (state == ST_MACK && cond.rise && cond.sda_lvl
        && !cond.stop && !cond.start |=> state == ST_IDLE ##1 !sda_oe)
        else $error("nack did not end read");
    a_ack_continue: assert property (state == ST_MACK && cond.rise && !cond.sda_lvl
        && !cond.stop && !cond.start |=> ptr == $past(ptr) + 8'h01)
        else $error("acked read did not advance");
    a_max_freq: assert property (ptr == OFF_MAX_FREQ |-> rd_val ==
        (pix_mode_mid ? 8'h55 : 8'hA2)) else $error("max freq value wrong");
    a_min_freq: assert property (ptr == OFF_MIN_FREQ |-> rd_val == 8'h19)
        else $error("min freq value wrong");
endmodule // tws_slave
`default_nettype wire

// file: testbench/tws_host_model.sv
/*
 Host bus master model: drives the serial clock and the open-drain data line.
 Assumes the bench resolves the data wire with the slave's pull-down and feeds it back.
*/
`timescale 1ns/1ns
`default_nettype none
module tws_host_model
(
    // Clock
    input wire logic ref_clk,
    // Resolved data wire
    input wire logic sda_wire,
    // Master drive, 1 means released to the pull-up
    output logic scl,
    output logic sda_drv
);
    // Bus idles released; the clock stands still between frames
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Inputs move only on the falling edge of the system clock
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // One bus clock: six cycles low, six high, data set mid-low, sampled mid-high
    task automatic clk_bit(input logic b, output logic seen);
        scl = 1'b0;
        tick(3);
        sda_drv = b;
        tick(3);
        scl = 1'b1;
        tick(3);
        seen = sda_wire;
        tick(3);
    endtask

    // Start, also usable as repeated start from the high clock phase
    task automatic start_c();
        scl = 1'b0;
        tick(3);
        sda_drv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
    endtask

    // Stop ends every frame, also after a withheld acknowledge
    task automatic stop_c();
        scl = 1'b0;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b1;
        tick(6);
    endtask

    // Byte out, most significant bit first, then the slave's acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask

    // Byte in, then the master's acknowledge or not-acknowledge
    task automatic recv_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, b[i]);
        clk_bit(!ack_it, s);
    endtask
endmodule // tws_host_model
`default_nettype wire

// file: testbench/tb_two_wire_slave_host_regs.sv
/*
 Self-checking bench for the two-wire register slave, driven by the host model.
 Assumes a 125 MHz ref_clk and a pull-up on the data wire.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_two_wire_slave_host_regs
    import tws_pkg::*;
;
    // Identity bytes handed to the design; values are arbitrary
    localparam logic [7:0] ID_VLO = 8'hC1;
    localparam logic [7:0] ID_VHI = 8'hD2;
    localparam logic [7:0] ID_PLO = 8'hE3;
    localparam logic [7:0] ID_PHI = 8'hF4;
    localparam logic [7:0] ID_REV = 8'h96;
    localparam logic [6:0] DEV = {ADDR_FIXED, 3'b101};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr_select = 3'b101;
    logic pix_mode_mid = 1'b0;
    logic panel_sense = 1'b0;
    logic [7:0] scaler_rdata = 8'h5A;
    logic scl, sda_drv, sda_out, sda_oe, power_normal, panel_attached, scaler_wr;
    logic [7:0] config_primary, scaler_addr, scaler_wdata;
    wire logic sda_wire;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int wr_seen = 0;
    logic a;
    logic [7:0] d;
    logic [7:0] exp_tbl [9];

    // Open-drain wire: anyone pulling low wins
    assign sda_wire = sda_drv & ~sda_oe;
    always #4 ref_clk = ~ref_clk;

    tws_host_model host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

    tws_slave #(.VENDOR_LO(ID_VLO), .VENDOR_HI(ID_VHI), .PART_LO(ID_PLO), .PART_HI(ID_PHI),
        .REVISION(ID_REV)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select(addr_select),
        .pix_mode_mid(pix_mode_mid), .panel_sense(panel_sense),
        .config_primary(config_primary), .power_normal(power_normal),
        .panel_attached(panel_attached), .scaler_wr(scaler_wr), .scaler_addr(scaler_addr),
        .scaler_wdata(scaler_wdata), .scaler_rdata(scaler_rdata));

    task automatic final_report();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Start plus address byte with direction flag
    task automatic addr_phase(input logic [6:0] dv, input logic rw, output logic ack);
        host.start_c();
        host.send_byte({dv, rw}, ack);
    endtask

    // Byte write; returns the data byte's acknowledge
    task automatic wr(input logic [7:0] ra, input logic [7:0] dat, output logic ack);
        addr_phase(DEV, 1'b0, ack);
        check({7'h00, ack}, 8'h01);
        host.send_byte(ra, ack);
        check({7'h00, ack}, 8'h01);
        host.send_byte(dat, ack);
        host.stop_c();
    endtask

    // Random read: register byte, repeated start, one byte closed by not-acknowledge
    task automatic rd(input logic [7:0] ra, output logic [7:0] dat);
        logic k;
        addr_phase(DEV, 1'b0, k);
        host.send_byte(ra, k);
        addr_phase(DEV, 1'b1, k);
        check({7'h00, k}, 8'h01);
        host.recv_byte(1'b0, dat);
        host.stop_c();
    endtask

    // Scaler write strobes are counted as they happen
    always @(posedge ref_clk)
        if (scaler_wr === 1'b1)
            wr_seen <= wr_seen + 1;

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            final_report();
        end
    end

    initial
    begin
        exp_tbl = '{ID_VLO, ID_VHI, ID_PLO, ID_PHI, ID_REV, VAL_RSVD_FIXED, VAL_MIN_FREQ,
            VAL_MAX_FREQ_FULL, RST_CONFIG1};
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        host.tick(4);
        check(config_primary, RST_CONFIG1);
        check({7'h00, power_normal}, 8'h01);
        // Sequential read of the whole host table from offset 00h
        addr_phase(DEV, 1'b0, a);
        check({7'h00, a}, 8'h01);
        host.send_byte(OFF_VENDOR_LO, a);
        addr_phase(DEV, 1'b1, a);
        check({7'h00, a}, 8'h01);
        for (int i = 0; i < 9; i++)
        begin
            host.recv_byte(i != 8, d);
            check(d, exp_tbl[i]);
        end
        check({7'h00, sda_oe}, 8'h00);
        host.stop_c();
        // Pointer stays on the last byte handed out under not-acknowledge
        addr_phase(DEV, 1'b1, a);
        host.recv_byte(1'b0, d);
        host.stop_c();
        check(d, RST_CONFIG1);
        // Select pins moved after the first frame: old address still answers
        addr_select = 3'b010;
        addr_phase({ADDR_FIXED, 3'b010}, 1'b0, a);
        host.stop_c();
        check({7'h00, a}, 8'h00);
        addr_phase({4'h6, 3'b101}, 1'b0, a);
        host.stop_c();
        check({7'h00, a}, 8'h00);
        wr(OFF_CONFIG1, 8'hFE, a);
        check({7'h00, a}, 8'h01);
        check(config_primary, 8'hFE & CONFIG_PRIMARY_WMASK);
        host.tick(2);
        check({7'h00, power_normal}, 8'h00);
        // Auto-increment write runs into the read-only reserved byte
        addr_phase(DEV, 1'b0, a);
        host.send_byte(OFF_PART_HI, a);
        host.send_byte(8'h11, a);
        check({7'h00, a}, 8'h01);
        host.send_byte(8'h22, a);
        check({7'h00, a}, 8'h01);
        host.send_byte(8'h33, a);
        check({7'h00, a}, 8'h00);
        host.stop_c();
        addr_phase(DEV, 1'b1, a);
        host.recv_byte(1'b0, d);
        host.stop_c();
        check(d, VAL_RSVD_FIXED);
        rd(OFF_PART_HI, d);
        check(d, 8'h11);
        rd(OFF_REVISION, d);
        check(d, 8'h22);
        // Read-only places refuse data and keep their contents
        wr(OFF_MIN_FREQ, 8'hFF, a);
        check({7'h00, a}, 8'h00);
        rd(OFF_MIN_FREQ, d);
        check(d, VAL_MIN_FREQ);
        wr(OFF_VENDOR_LO, 8'h00, a);
        check({7'h00, a}, 8'h00);
        pix_mode_mid = 1'b1;
        rd(OFF_MAX_FREQ, d);
        check(d, VAL_MAX_FREQ_MID);
        // Scaler window write and read pass through
        wr(OFF_SCALER_BASE, 8'hC7, a);
        check({7'h00, a}, 8'h01);
        check(8'(wr_seen), 8'h01);
        check(scaler_addr, OFF_SCALER_BASE);
        check(scaler_wdata, 8'hC7);
        rd(8'h85, d);
        check(d, scaler_rdata);
        panel_sense = 1'b1;
        host.tick(3);
        check({7'h00, panel_attached}, 8'h01);
        check({7'h00, sda_out}, 8'h00);
        final_report();
    end
endmodule // tb_two_wire_slave_host_regs
`default_nettype wire
